// [logic/obs_sequencer.sv]
// option byte erase, program and reload-after-reset sequencer
// assumes host keeps the documented unlock/poll sequences; storage is flip-flops
`timescale 1ns/1ns
// Overview of operation
// - erase or program sets end flag only if not-erased error is clear; interrupt if end interrupt enabled.
// - program unit is 32-bit word, or 64-bit double-word on wide variant.
// - eight byte pairs, upper byte of each is complement of lower.
// - complement bytes are generated internally; host complement data ignored.
// - check bits generated only for 64-bit option programming.
// - non-erased target and bad alignment or size raise program errors.
// - newly programmed values do not act until next reset.
// - after reset option area reloads into status and protect registers.
// - pair mismatch on reload sets mismatch error and forces 0xFF.
// - pair with both bytes 0xFF never sets mismatch error.
// - security byte 0xA5 none, 0xCC high, anything else low.
// - user bits 7:5 codes 001..100 give levels 1..4, else level 0.
// - user bit 3 enables sram parity check; bit 4 reserved.
// - user bit 2 low makes standby entry cause reset.
// - user bit 1 low makes deep-sleep entry cause reset.
// - user bit 0 low hardware watchdog, high software watchdog.
// - 16-bit user data in two pairs starting at fifth byte.
// - 32-bit protect mask in four pairs; zero bit means protected.
// - mask bits 0..30 guard 4KB each; bit 31 guards the rest.
// - option erase leaves all protection bits unprotected.
module obs_sequencer
    import obs_pkg::*;
#(
    parameter bit WIDE = 1'b0,
    parameter logic [15:0] INIT_AREA_LO = 16'hffff
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic option_write_enabled_flag,
    input wire logic option_erase_select,
    input wire logic option_program_select,
    input wire logic start,
    input wire logic end_interrupt_enable,
    input wire logic end_flag_clear,
    input wire logic error_flag_clear,
    input wire logic bus_write,
    input wire logic [3:0] bus_addr,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_wdata,
    output logic busy,
    output logic operation_end_flag,
    output logic end_irq,
    output logic program_not_erased_error,
    output logic program_alignment_error,
    output logic option_mismatch_error,
    output logic [31:0] page_protect_reg,
    output logic [15:0] user_data,
    output logic [1:0] security_level,
    output logic [2:0] brownout_level,
    output logic sram_parity_enable,
    output logic standby_reset_disable,
    output logic deepsleep_reset_disable,
    output logic watchdog_software_mode,
    output logic [7:0] check_bits
);
    obs_state_t state_r, state_nxt;
    logic [7:0] area_r [OBS_PAIRS*2];
    logic [7:0] area_nxt [OBS_PAIRS*2];
    logic [7:0] opt_r [OBS_PAIRS];
    logic [7:0] opt_nxt [OBS_PAIRS];
    logic [OBS_IDX_W-1:0] idx_r, idx_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [63:0] acc_r, acc_nxt;
    logic [1:0] part_r, part_nxt;
    logic [1:0] size_r, size_nxt;
    logic [3:0] base_r, base_nxt;
    logic busy_nxt, end_nxt, irq_nxt, pge_nxt, pga_nxt, mis_nxt;
    logic [7:0] chk_nxt;
    logic [7:0] lo, hi;
    logic [1:0] need;
    logic [3:0] unit_mask;
    logic bad;
    logic [3:0] p;

    assign lo = area_r[{idx_r, 1'b0}];
    assign hi = area_r[{idx_r, 1'b1}];
    assign need = WIDE ? ((bus_size == OBS_SZ_WORD) ? 2'd1 : 2'd3) : ((bus_size == OBS_SZ_WORD) ? 2'd0 : 2'd1);
    assign unit_mask = WIDE ? 4'h7 : 4'h3;

    always_comb begin
        state_nxt = state_r;
        area_nxt = area_r;
        opt_nxt = opt_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        acc_nxt = acc_r;
        part_nxt = part_r;
        size_nxt = size_r;
        base_nxt = base_r;
        busy_nxt = busy;
        end_nxt = operation_end_flag & ~end_flag_clear;
        irq_nxt = 1'b0;
        pge_nxt = program_not_erased_error & ~error_flag_clear;
        pga_nxt = program_alignment_error & ~error_flag_clear;
        mis_nxt = option_mismatch_error;
        chk_nxt = check_bits;
        bad = 1'b0;
        p = 4'h0;
        case (state_r)
            OBS_LOAD: begin
                // reload one pair per cycle
                if (lo == ~hi) begin
                    opt_nxt[idx_r] = lo;
                end else begin
                    opt_nxt[idx_r] = OBS_ERASED;
                    if (!(lo == OBS_ERASED && hi == OBS_ERASED)) begin
                        mis_nxt = 1'b1;
                    end
                end
                idx_nxt = idx_r + 3'd1;
                if (idx_r == 3'(OBS_PAIRS - 1)) begin
                    state_nxt = OBS_IDLE;
                end
            end
            OBS_IDLE: begin
                if (option_write_enabled_flag && option_erase_select && start) begin
                    busy_nxt = 1'b1;
                    cnt_nxt = 8'(OBS_PROG_CYC);
                    state_nxt = OBS_ERASE;
                end else if (option_write_enabled_flag && option_program_select && bus_write) begin
                    bad = (bus_size != OBS_SZ_WORD && bus_size != OBS_SZ_HALF)
                        || (part_r != 2'd0 && bus_size != size_r)
                        || (bus_size == OBS_SZ_WORD ? bus_addr[1:0] != 2'h0 : bus_addr[0])
                        || (part_r != 2'd0 && (bus_addr & ~unit_mask) != base_r);
                    if (bad) begin
                        pga_nxt = 1'b1;
                        part_nxt = 2'd0;
                    end else begin
                        // collect halfwords/words into one program unit
                        // slot is the offset inside the unit, so a narrow unit at offset 4 lands low
                        if (bus_size == OBS_SZ_WORD) begin
                            acc_nxt[{WIDE & bus_addr[2], 5'd0} +: 32] = bus_wdata;
                        end else begin
                            acc_nxt[{WIDE & bus_addr[2], bus_addr[1], 4'd0} +: 16] = bus_wdata[15:0];
                        end
                        size_nxt = bus_size;
                        base_nxt = bus_addr & ~unit_mask;
                        if (part_r == need) begin
                            part_nxt = 2'd0;
                            busy_nxt = 1'b1;
                            cnt_nxt = 8'(OBS_PROG_CYC);
                            state_nxt = OBS_PROG;
                            // check bits only on 64-bit units
                            chk_nxt = WIDE ? 8'(^acc_nxt) : check_bits;
                        end else begin
                            part_nxt = part_r + 2'd1;
                        end
                    end
                end
            end
            OBS_ERASE: begin
                cnt_nxt = cnt_r - 8'd1;
                if (cnt_r == 8'd1) begin
                    // all ones: protection bits read unprotected
                    for (int i = 0; i < OBS_PAIRS * 2; i++) begin
                        area_nxt[i] = OBS_ERASED;
                    end
                    state_nxt = OBS_DONE;
                end
            end
            OBS_PROG: begin
                cnt_nxt = cnt_r - 8'd1;
                if (cnt_r == 8'd1) begin
                    state_nxt = OBS_DONE;
                    for (int i = 0; i < 4; i++) begin
                        p = base_r + 4'(2 * i);
                        if (WIDE || i < 2) begin
                            if (area_r[p] != OBS_ERASED || area_r[p + 4'd1] != OBS_ERASED) begin
                                pge_nxt = 1'b1;
                            end else begin
                                area_nxt[p] = acc_r[16*i +: 8];
                                area_nxt[p + 4'd1] = ~acc_r[16*i +: 8];
                            end
                        end
                    end
                end
            end
            OBS_DONE: begin
                busy_nxt = 1'b0;
                if (!pge_nxt) begin
                    end_nxt = 1'b1;
                    irq_nxt = end_interrupt_enable;
                end
                state_nxt = OBS_IDLE;
            end
            default: state_nxt = OBS_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= OBS_LOAD;
            idx_r <= '0;
            cnt_r <= '0;
            acc_r <= '0;
            part_r <= '0;
            size_r <= '0;
            base_r <= '0;
            busy <= 1'b0;
            operation_end_flag <= 1'b0;
            end_irq <= 1'b0;
            program_not_erased_error <= 1'b0;
            program_alignment_error <= 1'b0;
            option_mismatch_error <= 1'b0;
            check_bits <= '0;
            for (int i = 0; i < OBS_PAIRS; i++) begin
                opt_r[i] <= OBS_ERASED;
            end
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            acc_r <= acc_nxt;
            part_r <= part_nxt;
            size_r <= size_nxt;
            base_r <= base_nxt;
            busy <= busy_nxt;
            operation_end_flag <= end_nxt;
            end_irq <= irq_nxt;
            program_not_erased_error <= pge_nxt;
            program_alignment_error <= pga_nxt;
            option_mismatch_error <= mis_nxt;
            check_bits <= chk_nxt;
            opt_r <= opt_nxt;
        end
    end

    // nonvolatile area survives reset
    always_ff @(posedge clock) begin
        area_r <= area_nxt;
    end

    // active option values only change through reload
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            page_protect_reg <= '1;
            user_data <= '1;
            security_level <= OBS_LVL_LOW;
            brownout_level <= '0;
            sram_parity_enable <= 1'b1;
            standby_reset_disable <= 1'b1;
            deepsleep_reset_disable <= 1'b1;
            watchdog_software_mode <= 1'b1;
        end else if (state_r == OBS_LOAD && state_nxt == OBS_IDLE) begin
            page_protect_reg <= {opt_nxt[OBS_IDX_WP+3], opt_nxt[OBS_IDX_WP+2],
                opt_nxt[OBS_IDX_WP+1], opt_nxt[OBS_IDX_WP]};
            user_data <= {opt_nxt[OBS_IDX_DATA+1], opt_nxt[OBS_IDX_DATA]};
            security_level <= (opt_nxt[OBS_IDX_SEC] == OBS_SEC_NONE) ? OBS_LVL_NONE
                : (opt_nxt[OBS_IDX_SEC] == OBS_SEC_HIGH) ? OBS_LVL_HIGH : OBS_LVL_LOW;
            brownout_level <= (opt_nxt[OBS_IDX_USER][OBS_BOR_HI:OBS_BOR_LO] >= OBS_BOR_MIN
                && opt_nxt[OBS_IDX_USER][OBS_BOR_HI:OBS_BOR_LO] <= OBS_BOR_MAX)
                ? opt_nxt[OBS_IDX_USER][OBS_BOR_HI:OBS_BOR_LO] : 3'h0;
            sram_parity_enable <= opt_nxt[OBS_IDX_USER][OBS_BIT_PARITY];
            standby_reset_disable <= opt_nxt[OBS_IDX_USER][OBS_BIT_STDBY];
            deepsleep_reset_disable <= opt_nxt[OBS_IDX_USER][OBS_BIT_DPSLP];
            watchdog_software_mode <= opt_nxt[OBS_IDX_USER][OBS_BIT_WDG];
        end
    end

    property p_busy_done;
        @(posedge clock) disable iff (!rst_n)
        (state_r == OBS_DONE) |=> !busy && (operation_end_flag || program_not_erased_error);
    endproperty
    a_busy_done: assert property (p_busy_done) else $error("busy or end flag wrong at completion");

    property p_irq;
        @(posedge clock) disable iff (!rst_n)
        end_irq |-> operation_end_flag && $past(end_interrupt_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("end interrupt without enable");

    property p_erase_ones;
        @(posedge clock) disable iff (!rst_n)
        (state_r == OBS_ERASE && cnt_r == 8'd1) |=> area_r[OBS_IDX_WP*2] == OBS_ERASED;
    endproperty
    a_erase_ones: assert property (p_erase_ones) else $error("erase left protection active");

    property p_stable;
        @(posedge clock) disable iff (!rst_n)
        (state_r != OBS_LOAD) |=> $stable(page_protect_reg) && $stable(security_level);
    endproperty
    a_stable: assert property (p_stable) else $error("active options changed without reset");

    property p_busy_start;
        @(posedge clock) disable iff (!rst_n)
        (state_r == OBS_IDLE && state_nxt == OBS_ERASE) |=> busy [*3];
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not held during erase");

    property p_err_no_end;
        @(posedge clock) disable iff (!rst_n)
        (state_r == OBS_DONE && pge_nxt && !operation_end_flag) |=> !operation_end_flag && !end_irq;
    endproperty
    a_err_no_end: assert property (p_err_no_end) else $error("end flag raised on failed program");

    property p_pair_blank;
        @(posedge clock) disable iff (!rst_n)
        (state_r == OBS_LOAD && lo == OBS_ERASED && hi == OBS_ERASED && !option_mismatch_error)
            |=> !option_mismatch_error;
    endproperty
    a_pair_blank: assert property (p_pair_blank) else $error("blank pair raised mismatch error");
endmodule

// [inc/obs_pkg.sv]
// option byte sequencer package: geometry, field positions, decode codes, timing
// assumes a single 50 MHz system clock
package obs_pkg;
    localparam int OBS_PAIRS = 8;
    localparam int OBS_IDX_W = 3;
    localparam logic [7:0] OBS_ERASED = 8'hff;
    localparam logic [7:0] OBS_SEC_NONE = 8'ha5;
    localparam logic [7:0] OBS_SEC_HIGH = 8'hcc;
    localparam logic [1:0] OBS_LVL_NONE = 2'h0;
    localparam logic [1:0] OBS_LVL_LOW = 2'h1;
    localparam logic [1:0] OBS_LVL_HIGH = 2'h2;
    // pair indices within the option area
    localparam int OBS_IDX_SEC = 0;
    localparam int OBS_IDX_USER = 1;
    localparam int OBS_IDX_DATA = 2;
    localparam int OBS_IDX_WP = 4;
    // user byte fields
    localparam int OBS_BOR_HI = 7;
    localparam int OBS_BOR_LO = 5;
    localparam int OBS_BIT_PARITY = 3;
    localparam int OBS_BIT_STDBY = 2;
    localparam int OBS_BIT_DPSLP = 1;
    localparam int OBS_BIT_WDG = 0;
    localparam logic [2:0] OBS_BOR_MIN = 3'h1;
    localparam logic [2:0] OBS_BOR_MAX = 3'h4;
    // bus write sizes
    localparam logic [1:0] OBS_SZ_HALF = 2'h1;
    localparam logic [1:0] OBS_SZ_WORD = 2'h2;
    // per-word flash cell time
    localparam int OBS_CLK_MHZ = 50;
    localparam int OBS_PROG_NS = 100;
    localparam int OBS_PROG_CYC = (OBS_PROG_NS * OBS_CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {OBS_IDLE, OBS_LOAD, OBS_ERASE, OBS_PROG, OBS_DONE} obs_state_t;
endpackage

// [verification/obs_host.sv]
// host model: unlocks, requests option erase or program, polls busy
// assumes one clock with the sequencer; inputs change 1 ns after the edge
`timescale 1ns/1ns
module obs_host (
    input wire logic clock,
    input wire logic busy,
    input wire logic end_irq,
    output logic option_write_enabled_flag,
    output logic option_erase_select,
    output logic option_program_select,
    output logic start,
    output logic bus_write,
    output logic [3:0] bus_addr,
    output logic [1:0] bus_size,
    output logic [31:0] bus_wdata
);
    int busy_cycles;
    logic irq_seen;
    initial begin
        {option_write_enabled_flag, option_erase_select, option_program_select} = 3'h0;
        {start, bus_write, bus_addr, bus_size} = 8'h00;
        bus_wdata = 32'h0000_0000;
    end
    // wait for idle, then enable option writes and pick the operation
    task automatic prepare(input logic ers);
        for (int n = 0; n < 100 && busy !== 1'b0; n++) begin
            @(posedge clock);
            #1;
        end
        option_write_enabled_flag = 1'b1;
        option_erase_select = ers;
        option_program_select = !ers;
        @(posedge clock);
        #1;
    endtask
    // poll busy until clear, noting cycles and the end pulse
    task automatic poll();
        busy_cycles = 0;
        irq_seen = 1'b0;
        do begin
            @(posedge clock);
            #1;
            busy_cycles++;
            irq_seen = irq_seen | end_irq;
        end while (busy !== 1'b0 && busy_cycles < 100);
    endtask
    task automatic erase_op();
        prepare(1'b1);
        start = 1'b1;
        @(posedge clock);
        #1;
        start = 1'b0;
        poll();
    endtask
    task automatic write_op(input logic [3:0] a, input logic [1:0] s, input logic [31:0] d);
        prepare(1'b0);
        bus_addr = a;
        bus_size = s;
        bus_wdata = d;
        bus_write = 1'b1;
        @(posedge clock);
        #1;
        bus_write = 1'b0;
        bus_wdata = ~d;
        poll();
    endtask
endmodule

// [verification/testbench.sv]
// bench: erase, program and reload of the option area through the host model
// assumes narrow variant; area is unknown until the first erase
`timescale 1ns/1ns
module testbench;
    import obs_pkg::*;
    typedef struct {logic [7:0] sec; logic [7:0] usr; logic [1:0] lvl; logic [2:0] bor;} obs_row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic end_interrupt_enable = 1'b0;
    logic end_flag_clear = 1'b0;
    logic error_flag_clear = 1'b0;
    logic option_write_enabled_flag, option_erase_select, option_program_select, start, bus_write;
    logic [3:0] bus_addr;
    logic [1:0] bus_size, security_level;
    logic [31:0] bus_wdata, page_protect_reg;
    logic busy, operation_end_flag, end_irq, program_not_erased_error, program_alignment_error;
    logic option_mismatch_error, sram_parity_enable, standby_reset_disable, deepsleep_reset_disable;
    logic watchdog_software_mode;
    logic [15:0] user_data;
    logic [2:0] brownout_level;
    logic [7:0] check_bits;
    int err_count = 0;
    int num_checks = 0;
    int cycle_count = 0;
    obs_row_t rows [8] = '{'{8'ha5, 8'h00, OBS_LVL_NONE, 3'h0}, '{8'hcc, 8'h3f, OBS_LVL_HIGH, 3'h1},
        '{8'h00, 8'h55, OBS_LVL_LOW, 3'h2}, '{8'ha4, 8'h6a, OBS_LVL_LOW, 3'h3},
        '{8'hff, 8'h8f, OBS_LVL_LOW, 3'h4}, '{8'h5a, 8'hb0, OBS_LVL_LOW, 3'h0},
        '{8'ha5, 8'hc7, OBS_LVL_NONE, 3'h0}, '{8'hcc, 8'he9, OBS_LVL_HIGH, 3'h0}};
    always #10 clock = ~clock;
    obs_sequencer u_obs_sequencer (.clock, .rst_n, .option_write_enabled_flag, .option_erase_select,
        .option_program_select, .start, .end_interrupt_enable, .end_flag_clear, .error_flag_clear,
        .bus_write, .bus_addr, .bus_size, .bus_wdata, .busy, .operation_end_flag, .end_irq,
        .program_not_erased_error, .program_alignment_error, .option_mismatch_error, .page_protect_reg,
        .user_data, .security_level, .brownout_level, .sram_parity_enable, .standby_reset_disable,
        .deepsleep_reset_disable, .watchdog_software_mode, .check_bits);
    obs_host u_obs_host (.clock, .busy, .end_irq, .option_write_enabled_flag, .option_erase_select,
        .option_program_select, .start, .bus_write, .bus_addr, .bus_size, .bus_wdata);
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // reset, then let the 8-cycle reload land
    task automatic do_reset(input int n);
        rst_n = 1'b0;
        repeat (n) @(posedge clock);
        #1;
        check("rst", {busy, operation_end_flag, program_not_erased_error}, 3'h0);
        rst_n = 1'b1;
        repeat (10) @(posedge clock);
        #1;
    endtask
    task automatic clr();
        end_flag_clear = 1'b1;
        error_flag_clear = 1'b1;
        @(posedge clock);
        #1;
        end_flag_clear = 1'b0;
        error_flag_clear = 1'b0;
    endtask
    task automatic check_row(input int i);
        logic [7:0] u;
        u = rows[i].usr;
        check("lvl", security_level, rows[i].lvl);
        check("bor", brownout_level, rows[i].bor);
        check("par", sram_parity_enable, u[OBS_BIT_PARITY]);
        check("stby", standby_reset_disable, u[OBS_BIT_STDBY]);
        check("dslp", deepsleep_reset_disable, u[OBS_BIT_DPSLP]);
        check("wdg", watchdog_software_mode, u[OBS_BIT_WDG]);
        check("data", user_data, {rows[i].sec, u});
        check("wp", page_protect_reg, {~rows[i].sec, u, ~u, rows[i].sec});
        check("mis", option_mismatch_error, 1'b0);
    endtask
    always @(posedge clock) begin
        cycle_count++;
        if (cycle_count == 20000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        do_reset(6);
        u_obs_host.erase_op();
        for (int i = 0; i < 8; i++) begin
            do_reset(2);
            check("ewp", page_protect_reg, 32'hffff_ffff);
            check("emis", option_mismatch_error, 1'b0);
            end_interrupt_enable = i[0];
            clr();
            u_obs_host.write_op(4'h0, OBS_SZ_WORD, {8'h5a, rows[i].usr, 8'h5a, rows[i].sec});
            check("busy", u_obs_host.busy_cycles, OBS_PROG_CYC + 1);
            check("end", operation_end_flag, 1'b1);
            check("irq", u_obs_host.irq_seen, i[0]);
            check("chk", check_bits, 8'h00);
            u_obs_host.write_op(4'h4, OBS_SZ_WORD, {8'h00, rows[i].sec, 8'h00, rows[i].usr});
            u_obs_host.write_op(4'h8, OBS_SZ_WORD, {8'h00, ~rows[i].usr, 8'h00, rows[i].sec});
            u_obs_host.write_op(4'hc, OBS_SZ_WORD, {8'h00, ~rows[i].sec, 8'h00, rows[i].usr});
            check("hold", {security_level, page_protect_reg}, {OBS_LVL_LOW, 32'hffff_ffff});
            do_reset(2);
            check_row(i);
            u_obs_host.erase_op();
        end
        do_reset(2);
        u_obs_host.write_op(4'h4, OBS_SZ_HALF, 32'h003c_003c);
        check("half1", operation_end_flag, 1'b0);
        u_obs_host.write_op(4'h6, OBS_SZ_HALF, 32'h00c3_00c3);
        check("half2", operation_end_flag, 1'b1);
        do_reset(2);
        check("hdata", user_data, 16'hc33c);
        u_obs_host.write_op(4'h4, OBS_SZ_WORD, 32'h0000_0000);
        check("nerr", {program_not_erased_error, operation_end_flag}, 2'h2);
        clr();
        check("nclr", program_not_erased_error, 1'b0);
        u_obs_host.write_op(4'h8, 2'h0, 32'h0000_0000);
        check("size", program_alignment_error, 1'b1);
        clr();
        u_obs_host.write_op(4'h2, OBS_SZ_WORD, 32'h0000_0000);
        check("align", {program_alignment_error, operation_end_flag}, 2'h2);
        close_out();
    end
endmodule
